// >>> design/pod_pkg.sv
// shared constants and types of the pressure oscillation diagnostics block
package pod_pkg;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_HI = 8'h08;
	localparam logic [7:0] OFS_LO = 8'h0c;
	localparam logic [7:0] OFS_SRC = 8'h10;
	localparam logic [7:0] OFS_COEF = 8'h14;
	localparam logic [7:0] OFS_INDEX = 8'h18;
	localparam logic [7:0] OFS_IMAX = 8'h1c;
	localparam logic [7:0] OFS_IMIN = 8'h20;
	localparam logic [7:0] OFS_STDEV = 8'h24;
	localparam logic [7:0] OFS_STATUS = 8'h28;
	localparam logic [7:0] OFS_MASK = 8'h2c;
	localparam logic [7:0] OFS_ALARM = 8'h30;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTRL_RST_IDX_BIT = 0;
	localparam int CTRL_RST_SD_BIT = 1;
	localparam int IDX_VALID_BIT = 16;
	localparam int ST_IDX_DONE = 0;
	localparam int ST_HI_RISE = 1;
	localparam int ST_LO_RISE = 2;
	localparam int ST_SD_DONE = 3;
	// ----------------------------------------
	// reset values and encodings
	// ----------------------------------------
	typedef enum logic [1:0] {
		POD_AL_OFF = 2'b00,
		POD_AL_HI = 2'b01,
		POD_AL_LO = 2'b10,
		POD_AL_BOTH = 2'b11
	} pod_alarm_mode_t;
	localparam logic [15:0] HI_RST = 16'hffff;
	localparam logic [15:0] LO_RST = 16'h0000;
	localparam logic [3:0] SRC_D120 = 4'h0;
	localparam logic [3:0] SRC_D240 = 4'h1;
	localparam logic [3:0] SRC_D360 = 4'h2;
	localparam logic [3:0] SRC_S360 = 4'ha;
	localparam logic [8:0] COEF_RST = 9'h000;
	localparam logic [8:0] COEF_ONE = 9'h100;
	localparam logic [7:0] CH_FREQ_INDEX = 8'h32;
	localparam logic [1:0] RESP_OK = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int TICK_MS = 120;
	localparam int TICK_CYC = TICK_MS * 1000000 / CLK_PERIOD_NS;
	localparam int WIN_LOG2 = 10;
	localparam int SD_LOG2 = 10;
	localparam int IDX_SHIFT = 16 - WIN_LOG2;
endpackage

// >>> design/pod_hpf.sv
// first-order high-pass filter ahead of the oscillation counter
module pod_hpf
	import pod_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clr,
	input wire logic in_valid,
	input wire logic signed [15:0] in_data,
	input wire logic [8:0] coef,
	output logic out_valid,
	output logic signed [16:0] out_data
);
	typedef struct packed {
		logic signed [15:0] base;
		logic vld;
		logic signed [16:0] y;
	} pod_hpf_st_t;
	pod_hpf_st_t st_r;
	pod_hpf_st_t st_nxt;
	logic signed [16:0] diff;
	logic signed [26:0] prod;

	// baseline follows the input at a rate set by coef; 0 holds it, leaving the input untouched after reset or an index reset
	always_comb begin
		st_nxt = st_r;
		st_nxt.vld = 1'b0;
		diff = 17'(in_data) - 17'(st_r.base);
		prod = 27'(diff) * $signed({18'h0, coef});
		if (in_valid) begin
			st_nxt.y = diff;
			st_nxt.vld = 1'b1;
			st_nxt.base = 16'(st_r.base + 16'(prod >>> 8));
		end
		if (clr) begin
			st_nxt.base = 16'h0000;
			st_nxt.vld = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign out_valid = st_r.vld;
	assign out_data = st_r.y;
endmodule

// >>> design/pod_stdev.sv
// spread of the input pressure over a fixed block of samples
module pod_stdev
	import pod_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clr,
	input wire logic in_valid,
	input wire logic signed [15:0] in_data,
	output logic out_valid,
	output logic [31:0] out_var
);
	typedef struct packed {
		logic [SD_LOG2-1:0] cnt;
		logic signed [25:0] sum;
		logic [41:0] sq;
		logic [31:0] var_v;
		logic vld;
	} pod_sd_st_t;
	pod_sd_st_t st_r;
	pod_sd_st_t st_nxt;
	logic signed [25:0] tsum;
	logic [41:0] tsq;
	logic signed [15:0] mean;
	logic [31:0] mean2;
	logic [31:0] meansq;

	always_comb begin
		st_nxt = st_r;
		st_nxt.vld = 1'b0;
		tsum = st_r.sum + 26'(in_data);
		tsq = st_r.sq + 42'($unsigned(32'(in_data * in_data)));
		mean = 16'(tsum >>> SD_LOG2);
		mean2 = $unsigned(32'(mean * mean));
		meansq = 32'(tsq >> SD_LOG2);
		if (in_valid) begin
			st_nxt.sum = tsum;
			st_nxt.sq = tsq;
			st_nxt.cnt = st_r.cnt + 1'b1;
			if (&st_r.cnt) begin
				// mean of squares minus square of mean, floored at zero
				st_nxt.var_v = (meansq > mean2) ? meansq - mean2 : 32'h0;
				st_nxt.vld = 1'b1;
				st_nxt.sum = '0;
				st_nxt.sq = '0;
			end
		end
		if (clr) begin
			st_nxt = '0;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign out_valid = st_r.vld;
	assign out_var = st_r.var_v;
endmodule

// >>> design/pod_top.sv
// pressure oscillation diagnostics: frequency index, alarms, spread, register slave
//
// Our own choices: the AXI4-Lite slave port and the address map.
module pod_top
	import pod_pkg::*;
#(
	parameter logic [21:0] TICK_CYCLES = 22'(pod_pkg::TICK_CYC)
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic signed [15:0] differential_sample,
	input wire logic signed [15:0] static_sample,
	input wire logic differential_unit,
	output logic diag_alarm,
	output logic [7:0] index_ch_num,
	output logic [15:0] index_ch_value,
	output logic index_ch_valid,
	output logic index_ch_update,
	output logic [31:0] stdev_value,
	output logic irq
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [1:0] unit_sync;
		logic [21:0] tick_cnt;
		logic [1:0] div_cnt;
		logic awh;
		logic [7:0] awa;
		logic wh;
		logic [31:0] wd;
		logic [3:0] ws;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		pod_alarm_mode_t mode;
		logic [15:0] hi;
		logic [15:0] lo;
		logic [3:0] src;
		logic [8:0] coef;
		logic idx_clr;
		logic sd_clr;
		logic signed [16:0] prev;
		logic dir;
		logic have_prev;
		logic have_dir;
		logic [WIN_LOG2-1:0] win_cnt;
		logic [WIN_LOG2-1:0] rev_cnt;
		logic [15:0] idx;
		logic [15:0] imax;
		logic [15:0] imin;
		logic ivalid;
		logic [3:0] status;
		logic [3:0] mask;
		logic [1:0] alarm;
		logic upd;
	} pod_top_st_t;

	pod_top_st_t st_r;
	pod_top_st_t st_nxt;

	logic tick;
	logic [1:0] ticks_per_sample;
	logic sample_en;
	logic signed [15:0] sample_sel;
	logic hpf_valid;
	logic signed [16:0] hpf_data;
	logic sd_valid;
	logic [31:0] sd_var;
	logic [31:0] wmerged;
	logic [31:0] rmux;
	logic rmiss;
	logic wmiss;
	logic [WIN_LOG2:0] rev_total;
	logic [15:0] new_idx;
	logic up;
	logic hi_on;
	logic lo_on;
	logic [3:0] ev;
	logic [3:0] w1c;
	logic src_ok;

	// ----------------------------------------
	// sample pacing
	// ----------------------------------------
	assign tick = (st_r.tick_cnt == TICK_CYCLES - 22'h1);

	always_comb begin
		case (st_r.src)
			SRC_D240: ticks_per_sample = 2'h2;
			SRC_D360: ticks_per_sample = 2'h3;
			SRC_S360: ticks_per_sample = 2'h3;
			default: ticks_per_sample = 2'h1;
		endcase
	end

	assign sample_en = tick && (st_r.div_cnt == ticks_per_sample - 2'h1);
	// static sensor only reachable on differential units, the source write guards it
	assign sample_sel = (st_r.src == SRC_S360) ? static_sample : differential_sample;

	// ----------------------------------------
	// datapath helpers
	// ----------------------------------------
	pod_hpf u_hpf (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.clr(st_r.idx_clr),
		.in_valid(sample_en),
		.in_data(sample_sel),
		.coef(st_r.coef),
		.out_valid(hpf_valid),
		.out_data(hpf_data)
	);

	pod_stdev u_stdev (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.clr(st_r.sd_clr),
		.in_valid(sample_en),
		.in_data(sample_sel),
		.out_valid(sd_valid),
		.out_var(sd_var)
	);

	// ----------------------------------------
	// register read and write helpers
	// ----------------------------------------
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wmerged[b*8 +: 8] = st_r.ws[b] ? st_r.wd[b*8 +: 8] : 8'h00;
		end
	end

	always_comb begin
		rmiss = 1'b0;
		case (s_axi_araddr)
			OFS_CTRL: rmux = 32'h0;
			OFS_MODE: rmux = {30'h0, st_r.mode};
			OFS_HI: rmux = {16'h0, st_r.hi};
			OFS_LO: rmux = {16'h0, st_r.lo};
			OFS_SRC: rmux = {28'h0, st_r.src};
			OFS_COEF: rmux = {23'h0, st_r.coef};
			OFS_INDEX: rmux = {15'h0, st_r.ivalid, st_r.idx};
			OFS_IMAX: rmux = {15'h0, st_r.ivalid, st_r.imax};
			OFS_IMIN: rmux = {15'h0, st_r.ivalid, st_r.imin};
			OFS_STDEV: rmux = sd_var;
			OFS_STATUS: rmux = {28'h0, st_r.status};
			OFS_MASK: rmux = {28'h0, st_r.mask};
			OFS_ALARM: rmux = {30'h0, st_r.alarm};
			default: begin
				rmux = 32'h0;
				rmiss = 1'b1;
			end
		endcase
	end

	always_comb begin
		case (st_r.awa)
			OFS_CTRL, OFS_MODE, OFS_HI, OFS_LO, OFS_SRC, OFS_COEF: wmiss = 1'b0;
			OFS_INDEX, OFS_IMAX, OFS_IMIN, OFS_STDEV: wmiss = 1'b0;
			OFS_STATUS, OFS_MASK, OFS_ALARM: wmiss = 1'b0;
			default: wmiss = 1'b1;
		endcase
	end

	// gauge and absolute units refuse the static-sensor code; unknown codes are ignored
	always_comb begin
		case (wmerged[3:0])
			SRC_D120, SRC_D240, SRC_D360: src_ok = 1'b1;
			SRC_S360: src_ok = st_r.unit_sync[1];
			default: src_ok = 1'b0;
		endcase
	end

	// ----------------------------------------
	// index arithmetic
	// ----------------------------------------
	assign up = hpf_data > st_r.prev;
	assign rev_total = {1'b0, st_r.rev_cnt}
		+ (WIN_LOG2 + 1)'(st_r.have_dir && hpf_data != st_r.prev && up != st_r.dir);
	// reversals per window scaled to 0..1 in 16-bit fraction
	// a window that reverses on every sample saturates at full scale instead of wrapping to 0
	assign new_idx = rev_total[WIN_LOG2] ? 16'({WIN_LOG2{1'b1}} << IDX_SHIFT)
		: 16'(rev_total << IDX_SHIFT);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		ev = 4'h0;
		w1c = 4'h0;
		st_nxt.unit_sync = {st_r.unit_sync[0], differential_unit};
		st_nxt.idx_clr = 1'b0;
		st_nxt.sd_clr = 1'b0;
		st_nxt.upd = 1'b0;

		st_nxt.tick_cnt = tick ? 22'h0 : st_r.tick_cnt + 22'h1;
		if (sample_en) begin
			st_nxt.div_cnt = 2'h0;
		end else if (tick) begin
			st_nxt.div_cnt = st_r.div_cnt + 2'h1;
		end

		// oscillation window
		if (hpf_valid) begin
			st_nxt.prev = hpf_data;
			st_nxt.have_prev = 1'b1;
			if (st_r.have_prev && hpf_data != st_r.prev) begin
				st_nxt.dir = up;
				st_nxt.have_dir = 1'b1;
			end
			if (st_r.have_prev) begin
				st_nxt.rev_cnt = rev_total[WIN_LOG2-1:0];
				st_nxt.win_cnt = st_r.win_cnt + 1'b1;
				if (&st_r.win_cnt) begin
					st_nxt.idx = new_idx;
					st_nxt.ivalid = 1'b1;
					st_nxt.upd = 1'b1;
					st_nxt.imax = (!st_r.ivalid || new_idx > st_r.imax) ? new_idx : st_r.imax;
					st_nxt.imin = (!st_r.ivalid || new_idx < st_r.imin) ? new_idx : st_r.imin;
					st_nxt.rev_cnt = '0;
					st_nxt.win_cnt = '0;
					ev[ST_IDX_DONE] = 1'b1;
				end
			end
		end
		ev[ST_SD_DONE] = sd_valid;

		// alarm comparison
		hi_on = st_r.mode[0] && st_r.ivalid && st_r.idx > st_r.hi;
		lo_on = st_r.mode[1] && st_r.ivalid && st_r.idx < st_r.lo;
		st_nxt.alarm = {lo_on, hi_on};
		ev[ST_HI_RISE] = hi_on && !st_r.alarm[0];
		ev[ST_LO_RISE] = lo_on && !st_r.alarm[1];

		// write channel
		if (s_axi_awvalid && !st_r.awh) begin
			st_nxt.awh = 1'b1;
			st_nxt.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_r.wh) begin
			st_nxt.wh = 1'b1;
			st_nxt.wd = s_axi_wdata;
			st_nxt.ws = s_axi_wstrb;
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (st_r.awh && st_r.wh && !st_r.bvalid) begin
			st_nxt.awh = 1'b0;
			st_nxt.wh = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = wmiss ? RESP_SLVERR : RESP_OK;
			case (st_r.awa)
				OFS_CTRL: begin
					st_nxt.idx_clr = wmerged[CTRL_RST_IDX_BIT];
					st_nxt.sd_clr = wmerged[CTRL_RST_SD_BIT];
				end
				OFS_MODE: begin
					if (st_r.ws[0]) begin
						st_nxt.mode = pod_alarm_mode_t'(wmerged[1:0]);
					end
				end
				OFS_HI: st_nxt.hi = (wmerged[15:0] & {{8{st_r.ws[1]}}, {8{st_r.ws[0]}}})
					| (st_r.hi & ~{{8{st_r.ws[1]}}, {8{st_r.ws[0]}}});
				OFS_LO: st_nxt.lo = (wmerged[15:0] & {{8{st_r.ws[1]}}, {8{st_r.ws[0]}}})
					| (st_r.lo & ~{{8{st_r.ws[1]}}, {8{st_r.ws[0]}}});
				OFS_SRC: begin
					if (st_r.ws[0] && src_ok) begin
						st_nxt.src = wmerged[3:0];
					end
				end
				OFS_COEF: begin
					// values above 1.0 are held at 1.0
					if (st_r.ws[0] || st_r.ws[1]) begin
						st_nxt.coef = (wmerged[15:0] > 16'(COEF_ONE)) ? COEF_ONE
							: wmerged[8:0];
					end
				end
				OFS_STATUS: w1c = wmerged[3:0];
				OFS_MASK: begin
					if (st_r.ws[0]) begin
						st_nxt.mask = wmerged[3:0];
					end
				end
				default: begin
				end
			endcase
		end

		// index reset wipes the window so the next value is fresh
		if (st_nxt.idx_clr) begin
			st_nxt.idx = 16'h0000;
			st_nxt.imax = 16'h0000;
			st_nxt.imin = 16'h0000;
			st_nxt.ivalid = 1'b0;
			st_nxt.upd = 1'b0;
			st_nxt.win_cnt = '0;
			st_nxt.rev_cnt = '0;
			st_nxt.have_prev = 1'b0;
			st_nxt.have_dir = 1'b0;
			ev[ST_IDX_DONE] = 1'b0;
		end

		// a new event outranks a clear in the same cycle
		st_nxt.status = (st_r.status & ~w1c) | ev;

		// read channel
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !st_r.rvalid) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = rmux;
			st_nxt.rresp = rmiss ? RESP_SLVERR : RESP_OK;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
			st_r.mode <= POD_AL_OFF;
			st_r.hi <= HI_RST;
			st_r.lo <= LO_RST;
			st_r.src <= SRC_D120;
			st_r.coef <= COEF_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign s_axi_awready = !st_r.awh;
	assign s_axi_wready = !st_r.wh;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = !st_r.rvalid;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;
	assign diag_alarm = |st_r.alarm;
	assign index_ch_num = CH_FREQ_INDEX;
	assign index_ch_value = st_r.idx;
	assign index_ch_valid = st_r.ivalid;
	assign index_ch_update = st_r.upd;
	assign stdev_value = sd_var;
	assign irq = |(st_r.status & st_r.mask);
endmodule

// >>> tb/pod_checker.sv
// concurrent checks on the ports of the diagnostics block
module pod_checker (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic diag_alarm,
	input wire logic [7:0] index_ch_num,
	input wire logic [15:0] index_ch_value,
	input wire logic index_ch_valid,
	input wire logic index_ch_update
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	AST_CH_NUM: assert property (index_ch_num == 8'h32)
		else $error("index channel number wrong");
	AST_UPD_VALID: assert property (index_ch_update |-> index_ch_valid)
		else $error("new index not marked valid");
	AST_UPD_PULSE: assert property (index_ch_update |=> !index_ch_update)
		else $error("index update longer than one cycle");
	AST_ALARM_VALID: assert property (!index_ch_valid [*3] |-> !diag_alarm)
		else $error("alarm with no valid index");
	AST_VAL_UPD: assert property (index_ch_valid && $changed(index_ch_value) |->
		index_ch_update || $past(index_ch_update))
		else $error("index changed without update");
	AST_ALARM_SRC: assert property ($rose(diag_alarm) |->
		$past(index_ch_valid))
		else $error("alarm rose without a valid index");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	cover property (index_ch_update);
	cover property ($rose(diag_alarm));
	cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule

bind pod_top pod_checker u_chk (.ref_clk(ref_clk), .nrst(nrst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .diag_alarm(diag_alarm), .index_ch_num(index_ch_num),
	.index_ch_value(index_ch_value), .index_ch_valid(index_ch_valid),
	.index_ch_update(index_ch_update));

// >>> tb/pod_far_model.sv
// pressure source and trend channel listener around the diagnostics block
module pod_far_model #(
	parameter int TICK = 8
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [1:0] osc_mode,
	input wire logic index_ch_update,
	input wire logic [15:0] index_ch_value,
	output logic signed [15:0] differential_sample,
	output logic signed [15:0] static_sample,
	output logic [15:0] trend_value
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	logic ph;
	// phase flips once a base tick, so a one-tick sampler sees a reversal every sample
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 0;
			ph <= 1'b0;
			trend_value <= 16'h0000;
		end else begin
			cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
			if (cnt == TICK - 1) begin
				ph <= ~ph;
			end
			if (index_ch_update) begin
				trend_value <= index_ch_value;
			end
		end
	end
	assign differential_sample = (osc_mode == 2'd1 && ph) ? -16'sh0100 : 16'sh0100;
	assign static_sample = (osc_mode == 2'd2 && ph) ? -16'sh0100 : 16'sh0100;
endmodule

// >>> tb/pod_top_tb_top.sv
// self-checking bench of the pressure oscillation diagnostics block
module pod_top_tb_top;
	import pod_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 8;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic dunit = 1'b0;
	logic [1:0] osc = 2'd0;
	logic awready, wready, bvalid, arready, rvalid, alarm, chvalid, upd, irq;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata, sd, rv;
	logic [7:0] chnum;
	logic [15:0] chval, trend, idx3;
	logic signed [15:0] dsmp, ssmp;
	int error_cnt = 0;
	int checks = 0;

	always #20 ref_clk = ~ref_clk;

	pod_top #(.TICK_CYCLES(22'(TK))) uut (.ref_clk(ref_clk), .nrst(nrst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.differential_sample(dsmp), .static_sample(ssmp), .differential_unit(dunit),
		.diag_alarm(alarm), .index_ch_num(chnum), .index_ch_value(chval),
		.index_ch_valid(chvalid), .index_ch_update(upd), .stdev_value(sd), .irq(irq));

	pod_far_model #(.TICK(TK)) u_far (.ref_clk(ref_clk), .nrst(nrst), .osc_mode(osc),
		.index_ch_update(upd), .index_ch_value(chval), .differential_sample(dsmp),
		.static_sample(ssmp), .trend_value(trend));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask

	task automatic guard(input int n, input int lim, input string w);
		if (n > lim) begin
			chk(w, 32'h0, 32'h1);
			complete_run();
		end
	endtask

	// inputs change only by non-blocking assignment right after a rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			guard(n, 50, "write timeout");
		end while (!bvalid);
		rs = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (arready) arvalid <= 1'b0;
			guard(n, 50, "read timeout");
		end while (!rvalid);
		rv = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
		rd(a);
		chk(n, e, rv);
	endtask

	// the alarm follows a new index by one cycle, so two edges are let pass
	task automatic wait_upd();
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
			guard(n, 30000, "index update timeout");
		end while (!upd);
		repeat (2) @(posedge ref_clk);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [7:0] a[8] = '{OFS_MODE, OFS_HI, OFS_LO, OFS_SRC, OFS_COEF, OFS_MASK,
			OFS_STATUS, OFS_INDEX};
		logic [31:0] e[8] = '{32'h0, 32'hffff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
		for (int i = 0; i < 8; i++) rchk(a[i], e[i], "reset value");
		chk("channel number", 32'h32, 32'(chnum));
		chk("index valid", 32'h0, 32'(chvalid));
		rchk(8'h40, 32'h0, "unmapped read");
		chk("unmapped rresp", 32'h2, 32'(rs));
		wr(8'h40, 32'h1);
		chk("unmapped bresp", 32'h2, 32'(rs));
		$display("test reset values done");
	endtask

	task automatic t_src();
		wr(OFS_SRC, 32'ha);
		rchk(OFS_SRC, 32'h0, "static code on gauge unit");
		wr(OFS_SRC, 32'h2);
		rchk(OFS_SRC, 32'h2, "interval code 2");
		wr(OFS_SRC, 32'h3);
		rchk(OFS_SRC, 32'h2, "undefined code");
		dunit <= 1'b1;
		repeat (4) @(posedge ref_clk);
		wr(OFS_SRC, 32'ha);
		rchk(OFS_SRC, 32'ha, "static code on differential unit");
		wr(OFS_SRC, 32'h0);
		wr(OFS_COEF, 32'h1ff);
		rchk(OFS_COEF, 32'h100, "coefficient clamp");
		wr(OFS_COEF, 32'h0);
		$display("test source select done");
	endtask

	task automatic t_high();
		int n;
		osc <= 2'd1;
		wr(OFS_MODE, 32'h1);
		wr(OFS_HI, 32'h8000);
		wr(OFS_MASK, 32'h1);
		wr(OFS_CTRL, 32'h3);
		wait_upd();
		chk("index valid", 32'h1, 32'(chvalid));
		chk("index above high", 32'h1, 32'(chval > 16'h8000));
		chk("diag alarm high", 32'h1, 32'(alarm));
		rchk(OFS_ALARM, 32'h1, "alarm reg high only");
		rchk(OFS_INDEX, {16'h0001, chval}, "index reg");
		chk("trend channel", 32'(chval), 32'(trend));
		chk("irq unmasked", 32'h1, 32'(irq));
		idx3 = chval;
		wr(OFS_STATUS, 32'h7);
		chk("irq cleared", 32'h0, 32'(irq));
		n = 0;
		do begin
			rd(OFS_STATUS);
			n++;
			guard(n, 4000, "spread timeout");
		end while (!rv[ST_SD_DONE]);
		chk("spread", 32'h10000, sd);
		$display("test high alarm done");
	endtask

	task automatic t_low();
		osc <= 2'd0;
		wr(OFS_MODE, 32'h2);
		wr(OFS_LO, 32'h1000);
		wr(OFS_MASK, 32'h0);
		wait_upd();
		wait_upd();
		rchk(OFS_INDEX, 32'h10000, "steady index");
		rchk(OFS_IMIN, 32'h10000, "index minimum");
		rchk(OFS_IMAX, {16'h0001, idx3}, "index maximum");
		chk("diag alarm low", 32'h1, 32'(alarm));
		rchk(OFS_ALARM, 32'h2, "alarm reg low only");
		chk("irq masked", 32'h0, 32'(irq));
		rd(OFS_STATUS);
		chk("index done status", 32'h1, 32'(rv[ST_IDX_DONE]));
		$display("test low alarm done");
	endtask

	task automatic t_clear();
		wr(OFS_CTRL, 32'h1);
		rchk(OFS_INDEX, 32'h0, "index after clear");
		rchk(OFS_IMAX, 32'h0, "maximum after clear");
		rchk(OFS_IMIN, 32'h0, "minimum after clear");
		chk("valid after clear", 32'h0, 32'(chvalid));
		chk("alarm after clear", 32'h0, 32'(alarm));
		osc <= 2'd1;
		wr(OFS_MODE, 32'h0);
		wr(OFS_SRC, 32'h1);
		wr(OFS_CTRL, 32'h1);
		wait_upd();
		rchk(OFS_INDEX, 32'h10000, "index at 240 ms");
		chk("alarm mode off", 32'h0, 32'(alarm));
		$display("test clear and interval done");
	endtask

	task automatic t_static();
		osc <= 2'd2;
		wr(OFS_SRC, 32'ha);
		wr(OFS_MODE, 32'h3);
		wr(OFS_HI, 32'h4000);
		wr(OFS_LO, 32'h0);
		wr(OFS_CTRL, 32'h1);
		wait_upd();
		chk("static index high", 32'h1, 32'(chval > 16'h4000));
		rchk(OFS_ALARM, 32'h1, "alarm both modes");
		chk("diag alarm both", 32'h1, 32'(alarm));
		$display("test static sensor done");
	endtask

	initial begin
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		t_reset();
		t_src();
		t_high();
		t_low();
		t_clear();
		t_static();
		complete_run();
	end
endmodule
